// [core/serial_flash_status_cmd_logic.v]
// Instruction interpreter and status registers of a serial flash with one, two and four data lanes.
`timescale 1ns/1ps
`include "flash_cmd_defines.vh"
module serial_flash_status_cmd_logic #(
  parameter STATUS_WRITE_CYCLES = `STATUS_WRITE_CYCLES,
  // Arbitrary neutral identification value.
  parameter [7:0] DEVICE_CODE = 8'h5A
) (
  input wire mclk,
  input wire reset_n,
  input wire cs_n_pin,
  input wire sclk_pin,
  input wire [3:0] lane_in,
  input wire [7:0] array_data,
  input wire array_op_done,
  output reg [3:0] lane_out,
  output reg [3:0] lane_oe,
  output reg [23:0] array_addr,
  output reg [7:0] array_op_code,
  output reg array_op_req,
  output reg [7:0] status_reg_low,
  output reg [7:0] status_reg_high,
  output reg [2:0] wrap_length_bits
);
  localparam [6:0] ST_CMD = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_DUMMY = 7'h04;
  localparam [6:0] ST_DOUT = 7'h08;
  localparam [6:0] ST_WDATA = 7'h10;
  localparam [6:0] ST_HOLD = 7'h20;
  localparam [6:0] ST_IGNORE = 7'h40;

  wire [3:0] lane_s;
  wire cs_active;
  wire cs_fall;
  wire cs_rise;
  wire sclk_rise;
  wire sclk_fall;

  spi_pin_sync pins (
    .mclk(mclk),
    .reset_n(reset_n),
    .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin),
    .lane_in(lane_in),
    .lane_s(lane_s),
    .cs_active(cs_active),
    .cs_fall(cs_fall),
    .cs_rise(cs_rise),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall)
  );

  reg [6:0] state;
  reg [7:0] cmd;
  reg [3:0] kind;
  reg [5:0] cnt;
  reg [2:0] alanes;
  reg [5:0] aclks;
  reg has_mode;
  reg [3:0] dclks;
  reg [2:0] owidth;
  reg [1:0] src;
  reg wdata;
  reg addr_done;
  reg [31:0] ashift;
  reg [15:0] wshift;
  reg [9:0] fbits;
  reg [3:0] out_pos;
  reg [7:0] out_byte;
  reg [31:0] timer;
  reg nv_pending;
  reg [7:0] nv_low;
  reg [7:0] nv_high;
  reg vol_arm;
  reg cont_valid;
  reg [7:0] cont_cmd;

  wire busy = status_reg_low[`SR_BUSY];
  wire write_enable_latch = status_reg_low[`SR_WEL];
  wire [7:0] next_cmd = {cmd[6:0], lane_s[0]};

  reg [3:0] d_kind;
  reg [2:0] d_alanes;
  reg [5:0] d_aclks;
  reg d_mode;
  reg [3:0] d_dclks;
  reg [2:0] d_ow;
  reg [1:0] d_src;
  reg d_wdata;

  always @* begin
    d_kind = `K_IGNORE;
    d_alanes = 3'd1;
    d_aclks = 6'd0;
    d_mode = 1'b0;
    d_dclks = 4'd0;
    d_ow = 3'd1;
    d_src = `SRC_ARRAY;
    d_wdata = 1'b0;
    case (next_cmd)
      `OP_WEN: d_kind = `K_WEN;
      `OP_VWEN: d_kind = `K_VWEN;
      `OP_WDIS: d_kind = `K_WDIS;
      `OP_SR_LOW: begin
        d_kind = `K_SREAD;
        d_src = `SRC_LOW;
      end
      `OP_SR_HIGH: begin
        d_kind = `K_SREAD;
        d_src = `SRC_HIGH;
      end
      `OP_WRSR: begin
        d_kind = `K_SWRITE;
        d_wdata = 1'b1;
      end
      `OP_REL_ID: begin
        d_kind = `K_ID;
        d_aclks = 6'd24;
        d_src = `SRC_ID;
      end
      `OP_READ, `OP_FAST, `OP_SEC_RD, `OP_DUAL_OUT, `OP_QUAD_OUT: begin
        d_kind = `K_READ;
        d_aclks = 6'd24;
        d_dclks = (next_cmd == `OP_READ) ? 4'd0 : 4'd8;
        d_ow = (next_cmd == `OP_DUAL_OUT) ? 3'd2 : (next_cmd == `OP_QUAD_OUT) ? 3'd4 : 3'd1;
      end
      `OP_DUAL_IO: begin
        d_kind = `K_READ;
        d_alanes = 3'd2;
        d_aclks = 6'd16;
        d_mode = 1'b1;
        d_ow = 3'd2;
      end
      `OP_QUAD_IO, `OP_WORD_QIO, `OP_OCT_QIO: begin
        d_kind = `K_READ;
        d_alanes = 3'd4;
        d_aclks = 6'd8;
        d_mode = 1'b1;
        d_ow = 3'd4;
        d_dclks = (next_cmd == `OP_QUAD_IO) ? 4'd4 : (next_cmd == `OP_WORD_QIO) ? 4'd2 : 4'd0;
      end
      `OP_WRAP: begin
        d_kind = `K_WRAP;
        d_alanes = 3'd4;
        d_aclks = 6'd8;
      end
      `OP_PP, `OP_QPP, `OP_SEC_PR: begin
        d_kind = `K_ARRAY;
        d_aclks = 6'd24;
        d_wdata = 1'b1;
        d_ow = (next_cmd == `OP_QPP) ? 3'd4 : 3'd1;
      end
      `OP_SE, `OP_BE32, `OP_BE64, `OP_SEC_ER: begin
        d_kind = `K_ARRAY;
        d_aclks = 6'd24;
      end
      `OP_CE1, `OP_CE2: d_kind = `K_ARRAY;
      default: d_kind = `K_IGNORE;
    endcase
    if (d_kind == `K_READ && d_ow == 3'd4 && !status_reg_high[`SR_QE])
      d_kind = `K_IGNORE;
    if (busy && d_kind != `K_SREAD)
      d_kind = `K_IGNORE;
  end

  function [3:0] take;
    input [2:0] w;
    input [3:0] l;
    begin
      take = (w == 3'd4) ? l : (w == 3'd2) ? {2'b00, l[1:0]} : {3'b000, l[0]};
    end
  endfunction

  function [6:0] after_addr;
    input [3:0] dc;
    input [3:0] k;
    input wd;
    begin
      if (dc != 4'd0)
        after_addr = ST_DUMMY;
      else if (k == `K_READ || k == `K_ID || k == `K_SREAD)
        after_addr = ST_DOUT;
      else if (wd)
        after_addr = ST_WDATA;
      else
        after_addr = ST_HOLD;
    end
  endfunction

  reg [2:0] cur_w;
  reg [7:0] src_byte;
  reg [7:0] sel_byte;
  reg [7:0] shifted;
  reg [31:0] next_ashift;
  reg [7:0] w_low;
  reg [7:0] w_high;
  reg [7:0] new_low;
  reg [7:0] new_high;
  reg sec_ok;

  always @* begin
    cur_w = (state == ST_ADDR) ? alanes : (state == ST_WDATA) ? owidth : 3'd1;
    case (src)
      `SRC_LOW: src_byte = status_reg_low;
      `SRC_HIGH: src_byte = status_reg_high;
      `SRC_ID: src_byte = DEVICE_CODE;
      default: src_byte = array_data;
    endcase
    sel_byte = (out_pos == 4'd0) ? src_byte : out_byte;
    shifted = sel_byte << out_pos;
    next_ashift = (ashift << alanes) | {28'h0000000, take(alanes, lane_s)};
    w_low = (fbits == 10'd24) ? wshift[15:8] : wshift[7:0];
    w_high = wshift[7:0];
    new_low = (w_low & `SR_LOW_WMASK) | (status_reg_low & ~`SR_LOW_WMASK);
    if (fbits == 10'd24) begin
      new_high = (w_high & `SR_HIGH_WMASK) | (status_reg_high & ~`SR_HIGH_WMASK);
      new_high = new_high | (status_reg_high & `SR_HIGH_OTP);
      if (vol_arm)
        new_high = new_high | (status_reg_high & `SR_HIGH_STATUS_PROTECT_BIT1);
    end else begin
      new_high = status_reg_high & ~`SR_HIGH_SHORT_CLR;
    end
    sec_ok = (array_addr[23:16] == `SEC_UPPER) && (array_addr[15:8] == `SEC_REG1 ||
             array_addr[15:8] == `SEC_REG2 || array_addr[15:8] == `SEC_REG3);
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_HOLD;
      cmd <= 8'h00;
      kind <= `K_IGNORE;
      cnt <= 6'd0;
      alanes <= 3'd1;
      aclks <= 6'd0;
      has_mode <= 1'b0;
      dclks <= 4'd0;
      owidth <= 3'd1;
      src <= `SRC_ARRAY;
      wdata <= 1'b0;
      addr_done <= 1'b0;
      ashift <= 32'h00000000;
      wshift <= 16'h0000;
      fbits <= 10'd0;
      out_pos <= 4'd0;
      out_byte <= 8'h00;
      timer <= 32'h00000000;
      nv_pending <= 1'b0;
      nv_low <= 8'h00;
      nv_high <= 8'h00;
      vol_arm <= 1'b0;
      cont_valid <= 1'b0;
      cont_cmd <= 8'h00;
      lane_out <= 4'h0;
      lane_oe <= 4'h0;
      array_addr <= 24'h000000;
      array_op_code <= 8'h00;
      array_op_req <= 1'b0;
      status_reg_low <= `SR_LOW_RESET;
      status_reg_high <= `SR_HIGH_RESET;
      wrap_length_bits <= 3'h0;
    end else begin
      array_op_req <= 1'b0;
      if (cs_fall) begin
        fbits <= 10'd0;
        cnt <= 6'd0;
        out_pos <= 4'd0;
        addr_done <= 1'b0;
        cmd <= 8'h00;
        if (cont_valid && !busy) begin
          // Continuous read mode skips the opcode and starts with the address.
          cmd <= cont_cmd;
          kind <= `K_READ;
          state <= ST_ADDR;
        end else begin
          state <= ST_CMD;
        end
      end else if (cs_active && sclk_rise) begin
        if (fbits < 10'h3F0)
          fbits <= fbits + {7'h00, cur_w};
        cnt <= cnt + 6'd1;
        if (state == ST_CMD) begin
          cmd <= next_cmd;
          if (cnt == 6'd7) begin
            cnt <= 6'd0;
            kind <= d_kind;
            alanes <= d_alanes;
            aclks <= d_alanes == 3'd4 ? (d_mode ? 6'd8 : d_aclks) : (d_mode ? 6'd16 : d_aclks);
            has_mode <= d_mode;
            dclks <= d_dclks;
            owidth <= d_ow;
            src <= d_src;
            wdata <= d_wdata;
            if (d_kind == `K_IGNORE)
              state <= ST_IGNORE;
            else if (d_aclks != 6'd0)
              state <= ST_ADDR;
            else
              state <= after_addr(d_dclks, d_kind, d_wdata);
          end
        end else if (state == ST_ADDR) begin
          ashift <= next_ashift;
          if (cnt == aclks - 6'd1) begin
            cnt <= 6'd0;
            addr_done <= 1'b1;
            state <= after_addr(dclks, kind, wdata);
            if (kind == `K_WRAP)
              wrap_length_bits <= next_ashift[6:4];
            else if (has_mode) begin
              array_addr <= next_ashift[31:8];
              cont_valid <= (next_ashift[5:4] == 2'b10);
              cont_cmd <= cmd;
            end else begin
              array_addr <= next_ashift[23:0];
            end
          end
        end else if (state == ST_DUMMY) begin
          if (cnt == {2'b00, dclks} - 6'd1)
            state <= ST_DOUT;
        end else if (state == ST_WDATA) begin
          wshift <= (wshift << owidth) | {12'h000, take(owidth, lane_s)};
        end
      end else if (cs_active && sclk_fall && state == ST_DOUT) begin
        lane_oe <= (owidth == 3'd4) ? 4'hF : (owidth == 3'd2) ? 4'h3 : 4'h2;
        lane_out <= (owidth == 3'd4) ? shifted[7:4] : (owidth == 3'd2) ? {2'b00, shifted[7:6]} :
                    {2'b00, shifted[7], 1'b0};
        out_byte <= sel_byte;
        if (out_pos + {1'b0, owidth} >= 4'd8) begin
          out_pos <= 4'd0;
          if (src == `SRC_ARRAY)
            array_addr <= array_addr + 24'h000001;
        end else begin
          out_pos <= out_pos + {1'b0, owidth};
        end
      end else if (cs_rise) begin
        lane_oe <= 4'h0;
        lane_out <= 4'h0;
        state <= ST_HOLD;
        if (state != ST_IGNORE && state != ST_CMD && fbits[2:0] == 3'd0) begin
          case (kind)
            `K_WEN: status_reg_low[`SR_WEL] <= 1'b1;
            `K_VWEN: vol_arm <= 1'b1;
            `K_WDIS: begin
              status_reg_low[`SR_WEL] <= 1'b0;
              vol_arm <= 1'b0;
            end
            `K_SWRITE: begin
              // exactly 8 or 16 data bits
              if (fbits == 10'd16 || fbits == 10'd24) begin
                if (vol_arm) begin
                  status_reg_low <= new_low;
                  status_reg_high <= new_high;
                  vol_arm <= 1'b0;
                end else if (write_enable_latch) begin
                  status_reg_low[`SR_BUSY] <= 1'b1;
                  nv_low <= new_low;
                  nv_high <= new_high;
                  nv_pending <= 1'b1;
                  timer <= STATUS_WRITE_CYCLES;
                end
              end
            end
            `K_ARRAY: begin
              if (write_enable_latch && (addr_done || aclks == 6'd0) &&
                  (sec_ok || (cmd != `OP_SEC_ER && cmd != `OP_SEC_PR))) begin
                array_op_req <= 1'b1;
                array_op_code <= cmd;
                status_reg_low[`SR_BUSY] <= 1'b1;
              end
            end
            default: state <= ST_HOLD;
          endcase
        end
      end
      // Completion runs beside the frame logic so a done pulse that meets a pin edge is never lost.
      if (busy && nv_pending) begin
        if (timer <= 32'd1) begin
          status_reg_low <= (nv_low & `SR_LOW_WMASK) | 8'h00;
          status_reg_high <= nv_high;
          nv_pending <= 1'b0;
        end else begin
          timer <= timer - 32'd1;
        end
      end else if (busy && array_op_done) begin
        status_reg_low[`SR_BUSY] <= 1'b0;
        status_reg_low[`SR_WEL] <= 1'b0;
      end
    end
  end
endmodule // serial_flash_status_cmd_logic

// [core/flash_cmd_defines.vh]
// Opcodes, status bit layout, reset values and timing counts of the flash instruction interpreter.
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH
`define OP_WEN 8'h06
`define OP_VWEN 8'h50
`define OP_WDIS 8'h04
`define OP_SR_LOW 8'h05
`define OP_SR_HIGH 8'h35
`define OP_WRSR 8'h01
`define OP_READ 8'h03
`define OP_FAST 8'h0B
`define OP_DUAL_OUT 8'h3B
`define OP_QUAD_OUT 8'h6B
`define OP_DUAL_IO 8'hBB
`define OP_QUAD_IO 8'hEB
`define OP_WORD_QIO 8'hE7
`define OP_OCT_QIO 8'hE3
`define OP_WRAP 8'h77
`define OP_REL_ID 8'hAB
`define OP_SEC_RD 8'h48
`define OP_SEC_ER 8'h44
`define OP_SEC_PR 8'h42
`define OP_PP 8'h02
`define OP_QPP 8'h32
`define OP_SE 8'h20
`define OP_BE32 8'h52
`define OP_BE64 8'hD8
`define OP_CE1 8'hC7
`define OP_CE2 8'h60
`define SEC_REG1 8'h10
`define SEC_REG2 8'h20
`define SEC_REG3 8'h30
`define SEC_UPPER 8'h00
`define SR_BUSY 0
`define SR_WEL 1
`define SR_QE 1
`define SR_LOW_RESET 8'h00
`define SR_HIGH_RESET 8'h00
`define SR_LOW_WMASK 8'hFC
`define SR_HIGH_WMASK 8'h7B
`define SR_HIGH_OTP 8'h38
`define SR_HIGH_STATUS_PROTECT_BIT1 8'h01
`define SR_HIGH_SHORT_CLR 8'h42
`define K_IGNORE 4'h0
`define K_WEN 4'h1
`define K_VWEN 4'h2
`define K_WDIS 4'h3
`define K_SREAD 4'h4
`define K_SWRITE 4'h5
`define K_READ 4'h6
`define K_ARRAY 4'h7
`define K_WRAP 4'h8
`define K_ID 4'h9
`define SRC_LOW 2'h0
`define SRC_HIGH 2'h1
`define SRC_ID 2'h2
`define SRC_ARRAY 2'h3
`define STATUS_WRITE_TIME_NS 10000000
`define MCLK_MHZ 250
// Divide first: the product of the two figures would overflow a 32-bit integer.
`define STATUS_WRITE_CYCLES ((`STATUS_WRITE_TIME_NS / 1000) * `MCLK_MHZ)
`endif

// [core/spi_pin_sync.v]
// Two-flop synchronisers and edge detectors for the SPI pins.
`timescale 1ns/1ps
module spi_pin_sync (
  input wire mclk,
  input wire reset_n,
  input wire cs_n_pin,
  input wire sclk_pin,
  input wire [3:0] lane_in,
  output wire [3:0] lane_s,
  output wire cs_active,
  output wire cs_fall,
  output wire cs_rise,
  output wire sclk_rise,
  output wire sclk_fall
);
  reg [5:0] meta;
  reg [5:0] sync;
  reg prev_cs_n;
  reg prev_sclk;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // Clock resets to its idle low level so no false edge follows reset.
      meta <= 6'h1C;
      sync <= 6'h1C;
      prev_cs_n <= 1'b1;
      prev_sclk <= 1'b0;
    end else begin
      meta <= {sclk_pin, cs_n_pin, lane_in};
      sync <= meta;
      prev_cs_n <= sync[4];
      prev_sclk <= sync[5];
    end
  end

  // Data lanes ride the same two stages as the clock, so a detected edge sees the bits that went with it.
  assign lane_s = sync[3:0];
  assign cs_active = ~sync[4];
  assign cs_fall = prev_cs_n & ~sync[4];
  assign cs_rise = ~prev_cs_n & sync[4];
  assign sclk_rise = ~sync[4] & sync[5] & ~prev_sclk;
  assign sclk_fall = ~sync[4] & ~sync[5] & prev_sclk;
endmodule // spi_pin_sync

// [testbench/flash_cmd_checker_asserts.sv]
// Concurrent checks on the ports of the flash instruction interpreter.
`timescale 1ns/1ps
module flash_cmd_checker #(
  parameter STATUS_WRITE_CYCLES = 2500000
) (
  input wire mclk,
  input wire reset_n,
  input wire cs_n_pin,
  input wire [3:0] lane_oe,
  input wire array_op_req,
  input wire [7:0] status_reg_low,
  input wire [7:0] status_reg_high
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_oe_idle_cs: assert property (cs_n_pin [*6] |-> lane_oe == 4'h0)
    else $error("lanes driven while chip select is high");
  chk_oe_lane_sets: assert property (lane_oe == 4'h0 || lane_oe == 4'h2 || lane_oe == 4'h3 || lane_oe == 4'hF)
    else $error("illegal output lane enable pattern");
  chk_quad_gate: assert property (lane_oe == 4'hF |-> status_reg_high[1])
    else $error("four lanes driven without quad enable");
  chk_wel_on_cs: assert property ($rose(status_reg_low[1]) |-> $past(cs_n_pin))
    else $error("latch set inside a frame");
  chk_busy_min: assert property ($rose(status_reg_low[0]) |-> status_reg_low[0] [*8])
    else $error("busy dropped too early");
  chk_idle_wel: assert property ($fell(status_reg_low[0]) |-> ##[0:1] !status_reg_low[1])
    else $error("latch kept after cycle end");
  chk_busy_freeze: assert property (status_reg_low[0] [*3] |-> $stable(status_reg_high) && $stable(status_reg_low[7:1]))
    else $error("status changed while busy");
  chk_otp_sticky: assert property (|$past(status_reg_high[5:3]) |->
    (status_reg_high[5:3] & $past(status_reg_high[5:3])) == $past(status_reg_high[5:3]))
    else $error("lock bit returned to zero");
  chk_req_needs_wel: assert property (array_op_req |-> status_reg_low[1] && $past(cs_n_pin))
    else $error("array request without latch or inside frame");
  chk_ro_bits: assert property (status_reg_high[7] == 1'b0 && status_reg_high[2] == 1'b0)
    else $error("read-only status bit changed");
  cover property ($rose(status_reg_low[0]));
  cover property (lane_oe == 4'hF);
  cover property (array_op_req);
endmodule // flash_cmd_checker
bind serial_flash_status_cmd_logic flash_cmd_checker #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) i_chk (
  .mclk(mclk), .reset_n(reset_n), .cs_n_pin(cs_n_pin), .lane_oe(lane_oe), .array_op_req(array_op_req),
  .status_reg_low(status_reg_low), .status_reg_high(status_reg_high));

// [testbench/spi_host_model.sv]
// SPI host model that frames instructions and shifts bits on one, two or four lanes.
`timescale 1ns/1ps
module spi_host_model (
  input wire mclk,
  input wire [3:0] lane_out,
  input wire [3:0] lane_oe,
  output reg cs_n_pin,
  output reg sclk_pin,
  output wire [3:0] lane_in
);
  reg [3:0] h_oe = 4'h0;
  reg [3:0] h_val = 4'h0;
  reg [3:0] flt = 4'h0;
  reg [3:0] got_oe = 4'h0;
  initial cs_n_pin = 1'b1;
  initial sclk_pin = 1'b0;
  // Undriven lanes toggle so that a stale level never passes as data.
  always @(negedge mclk) flt <= ~flt;
  assign lane_in = (lane_oe & lane_out) | (~lane_oe & h_oe & h_val) | (~lane_oe & ~h_oe & flt);
  task automatic unit(input int w, input [3:0] v, output [3:0] got);
    h_oe = (w == 1) ? 4'hD : (w == 2) ? 4'h3 : (w == 4) ? 4'hF : 4'h0;
    h_val = (w == 1) ? {3'h6, v[0]} : v;
    repeat (16) @(negedge mclk);
    got = lane_in;
    got_oe = lane_oe;
    sclk_pin = 1'b1;
    repeat (15) @(negedge mclk);
    sclk_pin = 1'b0;
  endtask
  task automatic send(input int w, input [31:0] val, input int bits);
    reg [3:0] g;
    for (int i = bits - w; i >= 0; i -= w) unit(w, 4'((val >> i) & ((1 << w) - 1)), g);
  endtask
  task automatic recv(input int w, input int n, output [31:0] r);
    reg [3:0] g;
    r = 0;
    repeat (n) begin
      unit(0, 4'h0, g);
      r = (r << w) | ((w == 1) ? g[1] : (w == 2) ? g[1:0] : g);
    end
  endtask
  task automatic open_frame();
    repeat (4) @(negedge mclk);
    cs_n_pin = 1'b0;
  endtask
  task automatic close_frame();
    repeat (8) @(negedge mclk);
    cs_n_pin = 1'b1;
    h_oe = 4'h0;
    repeat (8) @(negedge mclk);
  endtask
endmodule // spi_host_model

// [testbench/tb_top.sv]
// Self-checking bench for the flash instruction interpreter and its status registers.
`timescale 1ns/1ps
module tb_top;
  localparam int SWC = 4000;
  // Arbitrary device code value.
  localparam [7:0] DEV = 8'h3C;
  reg mclk = 1'b0;
  reg reset_n = 1'b0;
  reg [7:0] array_data = 8'h00;
  reg array_op_done = 1'b0;
  wire cs_n_pin;
  wire sclk_pin;
  wire [3:0] lane_in;
  wire [3:0] lane_out;
  wire [3:0] lane_oe;
  wire [23:0] array_addr;
  wire [7:0] array_op_code;
  wire array_op_req;
  wire [7:0] status_reg_low;
  wire [7:0] status_reg_high;
  wire [2:0] wrap_length_bits;
  reg [7:0] exp_low = 8'h00;
  reg [7:0] exp_high = 8'h00;
  reg [7:0] pend_low = 8'h00;
  reg [7:0] pend_high = 8'h00;
  reg [31:0] r;
  reg [15:0] d;
  int n_errors = 0;
  int checks = 0;
  int seed = 33803;
  int n_req = 0;
  int dly = 0;
  always #2 mclk = ~mclk;
  serial_flash_status_cmd_logic #(.STATUS_WRITE_CYCLES(SWC), .DEVICE_CODE(DEV)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .lane_in(lane_in),
    .array_data(array_data), .array_op_done(array_op_done), .lane_out(lane_out), .lane_oe(lane_oe),
    .array_addr(array_addr), .array_op_code(array_op_code), .array_op_req(array_op_req),
    .status_reg_low(status_reg_low), .status_reg_high(status_reg_high), .wrap_length_bits(wrap_length_bits));
  spi_host_model i_host (.mclk(mclk), .lane_out(lane_out), .lane_oe(lane_oe), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .lane_in(lane_in));
  // The array answers every request with a done pulse some cycles later.
  always @(negedge mclk) begin
    array_data <= array_addr[7:0] ^ 8'hA5;
    array_op_done <= (dly == 1);
    if (array_op_req === 1'b1) begin
      n_req <= n_req + 1;
      dly <= 12;
    end else if (dly > 0) begin
      dly <= dly - 1;
    end
  end
  task automatic check8(input string what, input [7:0] exp, input [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic frame(input [31:0] v, input int bits);
    i_host.open_frame();
    i_host.send(1, v, bits);
    i_host.close_frame();
  endtask
  task automatic regs(input string s);
    check8("status low", exp_low, status_reg_low);
    check8("status high", exp_high, status_reg_high);
    $display("test %s finished", s);
  endtask
  // Status write through the interface, with the expected register update alongside.
  task automatic wr(input bit vol, input [15:0] v, input int bits);
    reg [7:0] keep;
    frame(vol ? 32'h50 : 32'h06, 8);
    frame({8'h01, v} >> (16 - bits), 8 + bits);
    keep = exp_high & (vol ? 8'h39 : 8'h38);
    pend_low = (exp_low & 8'h03) | (v[15:8] & 8'hFC);
    if (bits == 16)
      pend_high = (exp_high & 8'h84) | (v[7:0] & 8'h7B) | keep;
    else
      pend_high = exp_high & 8'hBD;
    // A non-volatile write shows only busy and the latch until its timed cycle ends.
    if (vol) begin
      exp_low = pend_low;
      exp_high = pend_high;
    end else begin
      exp_low = exp_low | 8'h03;
    end
  endtask
  task automatic rd_status();
    for (int k = 0; k < 2; k++) begin
      i_host.open_frame();
      i_host.send(1, k ? 8'h35 : 8'h05, 8);
      i_host.recv(1, 16, r);
      i_host.close_frame();
      check8("status read", k ? exp_high : exp_low, r[15:8]);
      check8("status repeat", k ? exp_high : exp_low, r[7:0]);
    end
  endtask
  task automatic qread(input [7:0] op, input [23:0] a, input bit qe);
    i_host.open_frame();
    i_host.send(1, op, 8);
    i_host.send(4, {a, 8'h00}, 32);
    i_host.recv(4, (op == 8'hEB) ? 4 : 2, r);
    check8("dummy oe", 8'h00, 8'(i_host.got_oe));
    i_host.recv(4, 4, r);
    check8("data oe", qe ? 8'h0F : 8'h00, 8'(i_host.got_oe));
    i_host.close_frame();
    if (qe) begin
      check8("quad byte", a[7:0] ^ 8'hA5, r[15:8]);
      check8("quad next", (a[7:0] + 8'h01) ^ 8'hA5, r[7:0]);
    end
  endtask
  task automatic wait_idle();
    int n = 0;
    while (status_reg_low[0] !== 1'b0 && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    if (n == 20000) begin
      n_errors++;
      $display("[ERR] busy expected 0 seen 1");
      finish_test();
    end
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    regs("reset");
    frame(32'h06, 8);
    exp_low = 8'h02;
    rd_status();
    frame(32'h04, 8);
    exp_low = 8'h00;
    regs("latch");
    repeat (3) begin
      d = 16'($random(seed)) & 16'h7CFE;
      wr(1, d, 16);
      regs("volatile write");
    end
    frame(32'h50, 8);
    frame(32'h04, 8);
    frame({16'h017C, 8'h00}, 24);
    regs("cancelled volatile");
    frame(32'h06, 8);
    frame({8'h01, 16'h7C00} >> 7, 17);
    exp_low = exp_low | 8'h02;
    regs("partial byte");
    d = 16'($random(seed)) & 16'h7C00;
    wr(0, d, 8);
    regs("busy");
    frame(32'h04, 8);
    rd_status();
    wait_idle();
    exp_low = pend_low & 8'hFC;
    exp_high = pend_high;
    regs("write done");
    qread(8'hEB, 24'h000120, 1'b0);
    wr(1, {exp_low, exp_high | 8'h02}, 16);
    qread(8'hEB, 24'h000124, 1'b1);
    qread(8'hE7, 24'h000136, 1'b1);
    for (int w = 0; w < 8; w++) begin
      i_host.open_frame();
      i_host.send(1, 8'h77, 8);
      i_host.send(4, ($random(seed) & 32'hFFFFFF8F) | (w << 4), 32);
      i_host.close_frame();
      check8("wrap", 8'(w), 8'(wrap_length_bits));
    end
    i_host.open_frame();
    i_host.send(1, {8'hAB, 24'h000000}, 32);
    i_host.recv(1, 16, r);
    i_host.close_frame();
    check8("id", DEV, r[15:8]);
    check8("id repeat", DEV, r[7:0]);
    i_host.open_frame();
    i_host.send(1, 8'h9A, 8);
    i_host.recv(1, 8, r);
    check8("unknown oe", 8'h00, 8'(i_host.got_oe));
    i_host.close_frame();
    regs("unknown");
    frame({8'h20, 24'h001000}, 32);
    check8("refused erase", 8'h00, 8'(n_req));
    frame(32'h06, 8);
    frame({8'h44, 24'h001000}, 32);
    check8("erase code", 8'h44, array_op_code);
    wait_idle();
    frame(32'h06, 8);
    frame({8'h44, 24'h004000}, 32);
    check8("outside window", 8'h01, 8'(n_req));
    frame(32'h04, 8);
    frame(32'h06, 8);
    frame({8'h20, 24'h002000}, 32);
    wait_idle();
    check8("requests", 8'h02, 8'(n_req));
    regs("array done");
    finish_test();
  end
endmodule // tb_top
